// [rtl/tsfd_defines.svh]
/*
 tsfd_defines.svh: register indices, field positions, reset values,
 selector codes and timing counts of the session register bank.
 Assumes inclusion by bare name from the watchdog and top design files.
*/
`ifndef TSFD_DEFINES_SVH
`define TSFD_DEFINES_SVH

// ============================================================
// register indices
`define TSFD_IDX_CTRL      3'h0
`define TSFD_IDX_LASTBLK   3'h1
`define TSFD_IDX_MIRBLK    3'h2
`define TSFD_IDX_WDT_LO    3'h3
`define TSFD_IDX_WDT_HI    3'h4
`define TSFD_IDX_STRETCH   3'h5
`define TSFD_IDX_STATUS    3'h6

// ============================================================
// control byte fields
`define TSFD_CTRL_SILENCE  7
`define TSFD_CTRL_PT       6
`define TSFD_CTRL_REL_HI   5
`define TSFD_CTRL_REL_LO   4
`define TSFD_CTRL_ASR_HI   3
`define TSFD_CTRL_ASR_LO   2
`define TSFD_CTRL_MIRROR   1
`define TSFD_CTRL_DIR      0

// ============================================================
// status and stretch byte fields
`define TSFD_ST_MSGREAD    7
`define TSFD_ST_HOSTLOCK   6
`define TSFD_ST_RDRLOCK    5
`define TSFD_ST_HOSTRDY    4
`define TSFD_ST_RDRRDY     3
`define TSFD_ST_HVERR      2
`define TSFD_ST_NVBUSY     1
`define TSFD_ST_FIELD      0
`define TSFD_STR_AUTH      1
`define TSFD_STR_EN        0

// ============================================================
// reset values
`define TSFD_RST_CTRL      8'h00
`define TSFD_RST_LASTBLK   8'h00
`define TSFD_RST_MIRBLK    8'hF8
`define TSFD_RST_WDT_LO    8'h48
`define TSFD_RST_WDT_HI    8'h08
`define TSFD_RST_STR_EN    1'h1

// ============================================================
// selector codes
`define TSFD_ASR_FIELD     2'h0
`define TSFD_ASR_CMD       2'h1
`define TSFD_ASR_SELECT    2'h2
`define TSFD_REL_FIELD     2'h0
`define TSFD_REL_HALT      2'h1
`define TSFD_REL_LASTBLK   2'h2

// ============================================================
// timing
`define TSFD_CLK_NS        40
`define TSFD_WDT_TICK_NS   9430
`define TSFD_WDT_TICK_CYC  (`TSFD_WDT_TICK_NS / `TSFD_CLK_NS)

`endif

// [rtl/tsfd_pkg.sv]
/*
 tsfd_pkg: carrier structs and state type of the session bank.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package tsfd_pkg;

   // host serial side request
   typedef struct packed {
      logic       start;
      logic       wr;
      logic       rd;
      logic [2:0] addr;
      logic [7:0] wdata;
   } tsfd_host_req_type;

   // reader side events
   typedef struct packed {
      logic       valid_cmd;
      logic       selected;
      logic       halt;
      logic       block_read;
      logic [7:0] block_addr;
      logic       buf_written;
      logic       buf_read;
      logic       access_start;
      logic       access_end;
   } tsfd_nfc_evt_type;

   typedef enum logic {
      FD_RELEASED,
      FD_ASSERTED
   } tsfd_fd_state_type;

endpackage

// [rtl/tsfd_sync.sv]
/*
 tsfd_sync: two flip-flop synchroniser for asynchronous levels.
 Assumes slowly changing levels; no pulse capture.
*/
`timescale 1ns/1ns
module tsfd_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rstn,
   // levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;

   generate
      if (W < 1) begin : g_chk
         $error("tsfd_sync width below one");
      end
   endgenerate

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule // tsfd_sync

// [rtl/tsfd_watchdog.sv]
/*
 tsfd_watchdog: host lock watchdog, tick prescaler and 16-bit count.
 Assumes load is a one-cycle pulse on a write of the high byte.
*/
`timescale 1ns/1ns
`include "tsfd_defines.svh"
module tsfd_watchdog #(
   parameter int TICK_CYC = `TSFD_WDT_TICK_CYC
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // control
   input  wire logic        load,
   input  wire logic [15:0] load_value,
   input  wire logic        run,
   // result
   output logic             expire
);
   logic [15:0] limit_reg;
   logic [15:0] count_reg;
   logic [15:0] pre_reg;

   generate
      if (TICK_CYC < 1 || TICK_CYC > 65535) begin : g_chk
         $error("tsfd_watchdog tick count out of range");
      end
   endgenerate

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         limit_reg <= {`TSFD_RST_WDT_HI, `TSFD_RST_WDT_LO};
      end else if (load) begin
         limit_reg <= load_value;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pre_reg   <= '0;
         count_reg <= '0;
         expire    <= 1'b0;
      end else if (!run) begin
         pre_reg   <= '0;
         count_reg <= '0;
         expire    <= 1'b0;
      end else if (pre_reg == 16'(TICK_CYC - 1)) begin
         pre_reg <= '0;
         if (count_reg + 16'h0001 >= limit_reg) begin
            expire <= 1'b1;
         end else begin
            count_reg <= count_reg + 16'h0001;
         end
      end else begin
         pre_reg <= pre_reg + 16'h0001;
      end
   end
endmodule // tsfd_watchdog

// [rtl/tsfd_top.sv]
/*
 tsfd_top: session register bank with arbitration, buffer and
 nonvolatile status, and the open-drain field detect output.
 Assumes host and reader ports come from logic on clk; field and
 supply levels are asynchronous and are synchronised here.
*/
// Behaviour
// - passthrough enable clears when reader field or host supply is off.
// - mirror enable clears when the supply is absent.
// - stretch byte bit 1 shows authentication failure limit reached.
// - stretch byte bits 7-2 always read zero on both sides.
// - message read flag sets on last block read, clears when status is read.
// - status bit 6 shows host lock; host may clear it, reader reads only.
// - status bit 5 shows reader lock, default zero.
// - status bit 4 shows buffer data ready for host.
// - status bit 3 shows buffer data ready for reader.
// - status bit 2 sticky high-voltage fault, host writes zero to clear.
// - status bit 1 shows write busy and blocks nonvolatile access.
// - status bit 0 shows field present, default zero.
// - control, block and watchdog bytes writable by host, read-only for the reader.
// - field detect pin only pulls low, never driven high.
// - assert selector picks field, first command or selection.
// - release selector picks field loss, halt or last block read.
// - in passthrough the pin signals reader write and reader fetch.
// - watchdog value takes effect only on high byte write.
// - watchdog expiry clears an unreleased host lock.
`timescale 1ns/1ns
`include "tsfd_defines.svh"
module tsfd_top
   import tsfd_pkg::*;
#(
   parameter int WDT_TICK_CYC = `TSFD_WDT_TICK_CYC
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rstn,
   // host serial side
   input  wire tsfd_host_req_type host_req,
   input  wire logic              host_busy,
   output logic [7:0]             host_rdata,
   // reader side
   input  wire logic              reader_rd,
   input  wire logic [2:0]        reader_addr,
   input  wire tsfd_nfc_evt_type  nfc_evt,
   output logic [7:0]             reader_rdata,
   // asynchronous levels
   input  wire logic              field_raw,
   input  wire logic              vcc_raw,
   // device status
   input  wire logic              auth_limit,
   input  wire logic              nv_busy_in,
   input  wire logic              hv_fault,
   // outputs
   output logic                   nv_access_block,
   output logic [7:0]             ctrl_out,
   output logic                   field_detect_pin_o,
   output logic                   field_detect_pin_oe
);

   // ============================================================
   // signals
   logic [7:0]        ctrl_reg;
   logic [7:0]        lastblk_reg;
   logic [7:0]        mirblk_reg;
   logic [7:0]        wdt_lo_reg;
   logic [7:0]        wdt_hi_reg;
   logic              msg_read_reg;
   logic              host_lock_reg;
   logic              reader_lock_reg;
   logic              host_rdy_reg;
   logic              reader_rdy_reg;
   logic              fetched_reg;
   logic              hv_err_reg;
   logic              field_prev_reg;
   logic              wdt_due_reg;
   tsfd_fd_state_type fd_reg;
   tsfd_fd_state_type fd_next;
   logic              field_s;
   logic              vcc_s;
   logic              field_fall;
   logic              host_wr_status;
   logic              status_read;
   logic              wdt_expire;
   logic              fd_pull;

   // ============================================================
   // helpers
   function automatic logic sel_hit(
      input logic [1:0] sel,
      input logic [1:0] c0,
      input logic [1:0] c1,
      input logic [1:0] c2,
      input logic       e0,
      input logic       e1,
      input logic       e2
   );
      logic hit;
      hit = 1'b0;
      if (sel == c0) begin
         hit = e0;
      end else if (sel == c1) begin
         hit = e1;
      end else if (sel == c2) begin
         hit = e2;
      end
      return hit;
   endfunction

   function automatic logic [7:0] rd_mux(input logic [2:0] a);
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         `TSFD_IDX_CTRL:    v = ctrl_reg;
         `TSFD_IDX_LASTBLK: v = lastblk_reg;
         `TSFD_IDX_MIRBLK:  v = mirblk_reg;
         `TSFD_IDX_WDT_LO:  v = wdt_lo_reg;
         `TSFD_IDX_WDT_HI:  v = wdt_hi_reg;
         `TSFD_IDX_STRETCH: v = {6'h00, auth_limit, `TSFD_RST_STR_EN};
         `TSFD_IDX_STATUS:  v = {msg_read_reg, host_lock_reg, reader_lock_reg,
                                 host_rdy_reg, reader_rdy_reg, hv_err_reg,
                                 nv_access_block, field_s};
         default:           v = 8'h00;
      endcase
      return v;
   endfunction

   // ============================================================
   // synchronisers
   tsfd_sync #(.W(2)) u_sync (
      .clk  (clk),
      .rstn (rstn),
      .d    ({field_raw, vcc_raw}),
      .q    ({field_s, vcc_s})
   );

   assign field_fall     = field_prev_reg && !field_s;
   assign host_wr_status = host_req.wr && host_req.addr == `TSFD_IDX_STATUS;
   assign status_read    = (host_req.rd && host_req.addr == `TSFD_IDX_STATUS) ||
                           (reader_rd && reader_addr == `TSFD_IDX_STATUS);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         field_prev_reg <= 1'b0;
      end else begin
         field_prev_reg <= field_s;
      end
   end

   // ============================================================
   // control byte
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg <= `TSFD_RST_CTRL;
      end else begin
         if (host_req.wr && host_req.addr == `TSFD_IDX_CTRL) begin
            ctrl_reg <= host_req.wdata;
         end
         if (!field_s || !vcc_s) begin
            ctrl_reg[`TSFD_CTRL_PT] <= 1'b0;
         end
         if (!vcc_s) begin
            ctrl_reg[`TSFD_CTRL_MIRROR] <= 1'b0;
         end
      end
   end

   AST_PT_OFF: assert property (@(posedge clk) disable iff (!rstn)
      (!field_s || !vcc_s) |=> !ctrl_reg[`TSFD_CTRL_PT])
      else $error("passthrough stayed on with an interface off");
   AST_MIRROR_OFF: assert property (@(posedge clk) disable iff (!rstn)
      !vcc_s |=> !ctrl_reg[`TSFD_CTRL_MIRROR])
      else $error("mirror stayed on without supply");

   // ============================================================
   // block and watchdog bytes
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lastblk_reg <= `TSFD_RST_LASTBLK;
         mirblk_reg  <= `TSFD_RST_MIRBLK;
         wdt_lo_reg  <= `TSFD_RST_WDT_LO;
         wdt_hi_reg  <= `TSFD_RST_WDT_HI;
      end else if (host_req.wr) begin
         unique case (host_req.addr)
            `TSFD_IDX_LASTBLK: lastblk_reg <= host_req.wdata;
            `TSFD_IDX_MIRBLK:  mirblk_reg  <= host_req.wdata;
            `TSFD_IDX_WDT_LO:  wdt_lo_reg  <= host_req.wdata;
            `TSFD_IDX_WDT_HI:  wdt_hi_reg  <= host_req.wdata;
            default: ;
         endcase
      end
   end

   // ============================================================
   // watchdog
   tsfd_watchdog #(.TICK_CYC(WDT_TICK_CYC)) u_wdt (
      .clk        (clk),
      .rstn       (rstn),
      .load       (host_req.wr && host_req.addr == `TSFD_IDX_WDT_HI),
      .load_value ({host_req.wdata, wdt_lo_reg}),
      .run        (vcc_s && host_lock_reg),
      .expire     (wdt_expire)
   );

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wdt_due_reg <= 1'b0;
      end else begin
         wdt_due_reg <= wdt_expire && host_lock_reg;
      end
   end

   // ============================================================
   // arbitration locks
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         host_lock_reg <= 1'b0;
      end else begin
         if (host_wr_status && !host_req.wdata[`TSFD_ST_HOSTLOCK]) begin
            host_lock_reg <= 1'b0;
         end
         if ((wdt_due_reg && !host_busy) || !vcc_s) begin
            host_lock_reg <= 1'b0;
         end
         if (host_req.start && !reader_lock_reg && vcc_s) begin
            host_lock_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reader_lock_reg <= 1'b0;
      end else if (nfc_evt.access_end || !field_s) begin
         reader_lock_reg <= 1'b0;
      end else if (nfc_evt.access_start && !host_lock_reg && !host_req.start) begin
         reader_lock_reg <= 1'b1;
      end
   end

   AST_LOCK_EXCL: assert property (@(posedge clk) disable iff (!rstn)
      !(host_lock_reg && reader_lock_reg))
      else $error("both interfaces hold the memory lock");
   AST_WDT_CLR: assert property (@(posedge clk) disable iff (!rstn)
      (wdt_due_reg && !host_busy && !host_req.start) |=> !host_lock_reg)
      else $error("watchdog expiry left host lock set");

   // ============================================================
   // buffer ready flags
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         host_rdy_reg   <= 1'b0;
         reader_rdy_reg <= 1'b0;
         fetched_reg    <= 1'b0;
      end else if (!ctrl_reg[`TSFD_CTRL_PT]) begin
         host_rdy_reg   <= 1'b0;
         reader_rdy_reg <= 1'b0;
         fetched_reg    <= 1'b0;
      end else begin
         if (host_req.rd && host_req.addr == `TSFD_IDX_CTRL && host_rdy_reg) begin
            host_rdy_reg <= 1'b0;
         end
         if (nfc_evt.buf_written) begin
            host_rdy_reg <= 1'b1;
         end
         if (host_req.wr && host_req.addr == `TSFD_IDX_CTRL) begin
            fetched_reg <= 1'b0;
         end
         if (nfc_evt.buf_read) begin
            reader_rdy_reg <= 1'b0;
            fetched_reg    <= 1'b1;
         end
         if (nfc_evt.access_end && host_lock_reg) begin
            reader_rdy_reg <= 1'b1;
         end
      end
   end

   // ============================================================
   // message read, fault and busy status
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         msg_read_reg <= 1'b0;
      end else if (nfc_evt.block_read && nfc_evt.block_addr == lastblk_reg) begin
         msg_read_reg <= 1'b1;
      end else if (status_read) begin
         msg_read_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hv_err_reg <= 1'b0;
      end else if (hv_fault) begin
         hv_err_reg <= 1'b1;
      end else if (host_wr_status && !host_req.wdata[`TSFD_ST_HVERR]) begin
         hv_err_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         nv_access_block <= 1'b0;
      end else begin
         nv_access_block <= nv_busy_in;
      end
   end

   AST_MSG_SET: assert property (@(posedge clk) disable iff (!rstn)
      (nfc_evt.block_read && nfc_evt.block_addr == lastblk_reg) |=> msg_read_reg)
      else $error("message read flag missed last block read");
   AST_MSG_CLR: assert property (@(posedge clk) disable iff (!rstn)
      (status_read && !nfc_evt.block_read) |=> !msg_read_reg)
      else $error("message read flag survived status read");
   AST_HV_STICKY: assert property (@(posedge clk) disable iff (!rstn)
      (hv_fault || (hv_err_reg && !(host_wr_status && !host_req.wdata[`TSFD_ST_HVERR])))
      |=> hv_err_reg)
      else $error("fault flag not sticky");
   AST_NV_BUSY: assert property (@(posedge clk) disable iff (!rstn)
      nv_busy_in |=> nv_access_block)
      else $error("busy status not shown");
   AST_NV_SHOWN: assert property (@(posedge clk) disable iff (!rstn)
      (host_req.rd && host_req.addr == `TSFD_IDX_STATUS)
      |=> host_rdata[`TSFD_ST_NVBUSY] == $past(nv_access_block))
      else $error("busy bit missing from status read");

   // ============================================================
   // read ports
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         host_rdata <= 8'h00;
      end else if (host_req.rd) begin
         host_rdata <= rd_mux(host_req.addr);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reader_rdata <= 8'h00;
      end else if (reader_rd) begin
         reader_rdata <= rd_mux(reader_addr);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_out <= `TSFD_RST_CTRL;
      end else begin
         ctrl_out <= ctrl_reg;
      end
   end

   AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!rstn)
      (reader_rd && reader_addr == `TSFD_IDX_STRETCH) |=> reader_rdata[7:2] == 6'h00)
      else $error("reserved stretch bits not zero");
   AST_FIELD_BIT: assert property (@(posedge clk) disable iff (!rstn)
      (reader_rd && reader_addr == `TSFD_IDX_STATUS)
      |=> reader_rdata[`TSFD_ST_FIELD] == $past(field_s))
      else $error("field bit does not follow field");

   // ============================================================
   // field detect pin
   assign fd_pull = ctrl_reg[`TSFD_CTRL_PT] ? (host_rdy_reg || fetched_reg) :
                    (fd_reg == FD_ASSERTED);

   always_comb begin
      fd_next = fd_reg;
      unique case (fd_reg)
         FD_RELEASED:
            if (sel_hit(ctrl_reg[`TSFD_CTRL_ASR_HI:`TSFD_CTRL_ASR_LO],
                        `TSFD_ASR_FIELD, `TSFD_ASR_CMD, `TSFD_ASR_SELECT,
                        field_s, nfc_evt.valid_cmd, nfc_evt.selected)) begin
               fd_next = FD_ASSERTED;
            end
         FD_ASSERTED:
            if (field_fall ||
                sel_hit(ctrl_reg[`TSFD_CTRL_REL_HI:`TSFD_CTRL_REL_LO],
                        `TSFD_REL_FIELD, `TSFD_REL_HALT, `TSFD_REL_LASTBLK,
                        !field_s, nfc_evt.halt,
                        nfc_evt.block_read && nfc_evt.block_addr == lastblk_reg)) begin
               fd_next = FD_RELEASED;
            end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fd_reg <= FD_RELEASED;
      end else begin
         fd_reg <= fd_next;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         field_detect_pin_o  <= 1'b0;
         field_detect_pin_oe <= 1'b0;
      end else begin
         field_detect_pin_o  <= 1'b0;
         field_detect_pin_oe <= fd_pull;
      end
   end

   AST_OPEN_DRAIN: assert property (@(posedge clk) disable iff (!rstn)
      field_detect_pin_oe |-> !field_detect_pin_o)
      else $error("field detect driven high");
   AST_PT_PULL: assert property (@(posedge clk) disable iff (!rstn)
      (ctrl_reg[`TSFD_CTRL_PT] && host_rdy_reg) |=> field_detect_pin_oe)
      else $error("handshake pull missing");

endmodule // tsfd_top

// [verif/tsfd_host_model.sv]
/*
 tsfd_host_model: host controller on the serial side of the bank.
 Assumes clk from the bench; bus cycles are called by hierarchy.
*/
`timescale 1ns/1ns
module tsfd_host_model
   import tsfd_pkg::*;
(
   // clock
   input  wire logic         clk,
   // serial requests
   output tsfd_host_req_type host_req,
   output logic              host_busy
);
   // ============================================================
   // one request, held for one taking edge
   initial begin
      host_req  = '0;
      host_busy = 1'b0;
   end
   task automatic req(input logic s, w, r, input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      host_req <= '{s, w, r, a, d};
      @(posedge clk);
      host_req <= '0;
   endtask
   // serial transfer still running
   task automatic busy(input logic b);
      @(posedge clk);
      host_busy <= b;
   endtask
endmodule // tsfd_host_model

// [verif/tag_session_status_and_field_detect_bench.sv]
/*
 bench: drives host, reader and levels, checks read data and pin.
 Assumes the host model file and design files are compiled first.
*/
`timescale 1ns/1ns
module tag_session_status_and_field_detect_bench;
   import tsfd_pkg::*;
   logic clk = 0, rstn = 0, reader_rd = 0, field_raw = 0, vcc_raw = 0;
   logic auth_limit = 0, nv_busy_in = 0, hv_fault = 0;
   logic [2:0] reader_addr = 0;
   tsfd_nfc_evt_type nfc_evt = '0;
   tsfd_host_req_type host_req;
   logic host_busy, nv_access_block, fd_o, fd_oe;
   logic [7:0] host_rdata, reader_rdata, ctrl_out, lb, d;
   logic [7:0] q[$];
   bit h1, h2, r1, r2;
   int err_count = 0, num_checks = 0;
   localparam logic [7:0] RV [8] = '{8'h00, 8'h00, 8'hF8, 8'h48, 8'h08, 8'h01, 8'h00, 8'h00};
   // ============================================================
   // instances
   tsfd_host_model i_tsfd_host_model (.clk(clk), .host_req(host_req), .host_busy(host_busy));
   tsfd_top #(.WDT_TICK_CYC(2)) i_tsfd_top (.clk(clk), .rstn(rstn), .host_req(host_req),
      .host_busy(host_busy), .host_rdata(host_rdata), .reader_rd(reader_rd),
      .reader_addr(reader_addr), .nfc_evt(nfc_evt), .reader_rdata(reader_rdata),
      .field_raw(field_raw), .vcc_raw(vcc_raw), .auth_limit(auth_limit),
      .nv_busy_in(nv_busy_in), .hv_fault(hv_fault), .nv_access_block(nv_access_block),
      .ctrl_out(ctrl_out), .field_detect_pin_o(fd_o), .field_detect_pin_oe(fd_oe));
   initial begin
      forever #20 clk = ~clk;
   end
   // ============================================================
   // checking
   task automatic chk(input logic [7:0] g, e);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("Error t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   always @(posedge clk) begin
      h1 <= host_req.rd;
      h2 <= h1;
      r1 <= reader_rd;
      r2 <= r1;
   end
   always @(negedge clk) begin
      if (h2) chk(host_rdata, q.pop_front());
      if (r2) chk(reader_rdata, q.pop_front());
   end
   task automatic conclude();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      conclude();
   end
   // ============================================================
   // stimulus tasks
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      i_tsfd_host_model.req(0, 1, 0, a, v);
   endtask
   task automatic hrd(input logic [2:0] a, input logic [7:0] e);
      q.push_back(e);
      i_tsfd_host_model.req(0, 0, 1, a, 8'h00);
      wt(2);
   endtask
   task automatic rrd(input logic [2:0] a, input logic [7:0] e);
      q.push_back(e);
      @(posedge clk);
      reader_rd   <= 1'b1;
      reader_addr <= a;
      @(posedge clk);
      reader_rd <= 1'b0;
      wt(2);
   endtask
   // bit15 cmd, 14 select, 13 halt, 12 block read, 11:4 block, 3 bufwr, 2 bufrd, 1/0 access
   task automatic ev(input logic [15:0] e);
      @(posedge clk);
      nfc_evt <= e;
      @(posedge clk);
      nfc_evt <= '0;
      wt(4);
   endtask
   task automatic fld(input logic v);
      @(posedge clk);
      field_raw <= v;
      wt(5);
   endtask
   // ============================================================
   // main sequence
   initial begin
      void'($urandom(5352));
      wt(10);
      rstn <= 1'b1;
      for (int i = 0; i < 8; i++) hrd(i[2:0], RV[i]);
      vcc_raw <= 1'b1;
      fld(1);
      rrd(6, 8'h01);
      for (int i = 1; i < 4; i++) begin
         d = 8'($urandom);
         if (i == 1) lb = d;
         wr(i[2:0], d);
         hrd(i[2:0], d);
         rrd(i[2:0], d);
      end
      auth_limit <= 1'b1;
      wr(5, 8'hFF);
      hrd(5, 8'h03);
      rrd(5, 8'h03);
      auth_limit <= 1'b0;
      ev({4'h1, lb, 4'h0});
      hrd(6, 8'h81);
      hrd(6, 8'h01);
      hv_fault   <= 1'b1;
      nv_busy_in <= 1'b1;
      wt(1);
      hv_fault <= 1'b0;
      wt(3);
      hrd(6, 8'h07);
      chk(nv_access_block, 8'h01);
      nv_busy_in <= 1'b0;
      wr(6, 8'h00);
      hrd(6, 8'h01);
      i_tsfd_host_model.req(1, 0, 0, 0, 8'h00);
      ev(16'h0002);
      rrd(6, 8'h41);
      wr(6, 8'h00);
      hrd(6, 8'h01);
      ev(16'h0002);
      hrd(6, 8'h21);
      ev(16'h0001);
      hrd(6, 8'h01);
      wr(3, 8'h08);
      wr(4, 8'h00);
      i_tsfd_host_model.req(1, 0, 0, 0, 8'h00);
      hrd(6, 8'h41);
      i_tsfd_host_model.busy(1'b1);
      wt(30);
      hrd(6, 8'h41);
      i_tsfd_host_model.busy(1'b0);
      wt(3);
      hrd(6, 8'h01);
      for (int i = 0; i < 3; i++) begin
         wr(0, 8'(i * 20));
         fld(0);
         fld(1);
         if (i > 0) ev(i == 1 ? 16'h8000 : 16'h4000);
         chk(fd_oe, 8'h01);
         if (i == 0) fld(0);
         else ev(i == 1 ? 16'h2000 : {4'h1, lb, 4'h0});
         chk(fd_oe, 8'h00);
         chk(fd_o, 8'h00);
      end
      fld(1);
      hrd(6, 8'h81);
      wr(0, 8'h40);
      ev(16'h0008);
      chk(fd_oe, 8'h01);
      hrd(6, 8'h11);
      hrd(0, 8'h40);
      wt(3);
      chk(fd_oe, 8'h00);
      i_tsfd_host_model.req(1, 0, 0, 0, 8'h00);
      ev(16'h0001);
      hrd(6, 8'h49);
      ev(16'h0004);
      chk(fd_oe, 8'h01);
      fld(0);
      hrd(0, 8'h00);
      fld(1);
      wr(0, 8'h02);
      hrd(0, 8'h02);
      vcc_raw <= 1'b0;
      wt(5);
      hrd(0, 8'h00);
      chk(ctrl_out, 8'h00);
      conclude();
   end
endmodule // tag_session_status_and_field_detect_bench
